/* hdl/port_pins_remap.sv */
// port pins, change notification and peripheral input remapping
// Operation
// [RULE1] open-drain bit makes pin only pull low
// [RULE2] analog inputs need direction set to input
// [RULE3] analog configuration resets to all zeros
// [RULE4] analog pins read zero from pin value
// [RULE5] software waits one cycle before port read
// [RULE6] bit set/clear on pin value uses pins
// [RULE7] enabled pin change raises interrupt, even sleeping
// [RULE8] up to 31 change inputs, two enables
// [RULE9] per-pin weak pull-ups from two registers
// [RULE10] software disables pull-ups on digital outputs
// [RULE11] remapping spans up to 26 pins
// [RULE12] 5-bit field per input selects pin
// [RULE13] selection values limited to pin count
// [RULE14] remapping never overrides pin direction
// [RULE15] input and output mapping independent
// [RULE16] lock blocks map writes; key 0x46,0x57
// [RULE17] all-ones selects ground; fields reset ones
// [RULE18] direction one is input; reset as input
// [RULE19] pin value reads pins, writes latch
// [RULE20] compare enabled levels with previous samples
// [RULE21] remap pins pass two-stage synchroniser
`include "gpio_remap_defines.svh"

module port_pins_remap #(
  parameter int PORT_W = 16,
  parameter int CHG_W = 31,
  parameter int REMAP_PINS = 26,
  parameter int MAP_INPUTS = 14,
  parameter int SEL_W = 5
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // register port
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // port pins
  input wire logic [PORT_W-1:0] pin_i,
  output logic [PORT_W-1:0] pin_o,
  output logic [PORT_W-1:0] pin_oe_o,
  output logic [PORT_W-1:0] analog_sel_o,
  // change notification pins
  input wire logic [CHG_W-1:0] change_notify_pin_i,
  output logic [CHG_W-1:0] pullup_en_o,
  output logic change_irq_o,
  // remappable pins and peripheral inputs
  input wire logic [REMAP_PINS-1:0] remap_pin_i,
  output logic [MAP_INPUTS-1:0] periph_in_o,
  output logic map_write_lock_o
);
  gpio_remap_pkg::reg_req_t req;
  gpio_remap_pkg::key_state_t key_state;
  logic [PORT_W-1:0] pin_direction_reg;
  logic [PORT_W-1:0] output_latch_reg;
  logic [PORT_W-1:0] open_drain_ctl;
  logic [PORT_W-1:0] analog_pin_cfg;
  logic [15:0] change_irq_enable_1;
  logic [15:0] change_irq_enable_2;
  logic [15:0] pullup_enable_1;
  logic [15:0] pullup_enable_2;
  logic [SEL_W-1:0] map_sel [MAP_INPUTS];
  logic map_write_lock;
  logic [PORT_W-1:0] pin_sync;
  logic [REMAP_PINS-1:0] remap_sync;
  logic [CHG_W-1:0] chg_sync;
  logic [PORT_W-1:0] pin_value;
  logic chg_clear;
  logic map_hit;
  logic [`ADDR_W-1:0] map_idx;
  logic [31:0] chg_en_all;
  logic [31:0] pu_all;

  // bundle the bus request once for the decoders
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // selected pin level, ground for all-ones or out-of-range codes
  function automatic logic pick_pin(input logic [SEL_W-1:0] sel,
                                    input logic [REMAP_PINS-1:0] pins);
    logic r;
    r = 1'b0;
    if (sel != `MAP_SEL_GND && int'(sel) < REMAP_PINS) begin // [RULE13]
      r = pins[sel]; // [RULE12] [RULE17]
    end
    return r;
  endfunction

  // write strobe aimed at one offset
  function automatic logic wr_at(input gpio_remap_pkg::reg_req_t q,
                                 input logic [`ADDR_W-1:0] off);
    return q.wr && q.addr == off;
  endfunction

  // map word k carries inputs 2k and 2k+1
  function automatic logic in_slot(input int i, input logic [`ADDR_W-1:0] idx);
    return i / 2 == int'(idx);
  endfunction

  // port pins, remap pins and change pins each pass two flops
  pin_sync2 #(.WIDTH(PORT_W)) u_port_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(pin_i),
    .sync_o(pin_sync)
  );

  pin_sync2 #(.WIDTH(REMAP_PINS)) u_remap_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(remap_pin_i),
    .sync_o(remap_sync) // [RULE21] [RULE11]
  );

  pin_sync2 #(.WIDTH(CHG_W)) u_chg_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(change_notify_pin_i),
    .sync_o(chg_sync)
  );

  // enable and pull-up words joined, top bit unused
  assign chg_en_all = {change_irq_enable_2, change_irq_enable_1};
  assign pu_all = {pullup_enable_2, pullup_enable_1};

  change_detect #(.WIDTH(CHG_W)) u_change (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .level_i(chg_sync),
    .enable_i(chg_en_all[CHG_W-1:0]), // [RULE8]
    .clear_i(chg_clear),
    .flag_o(change_irq_o) // [RULE7]
  );

  // writing any value to the status register clears the change flag
  assign chg_clear = wr_at(req, `OFF_CHG_STATUS);

  // analog pins read low
  assign pin_value = pin_sync & analog_pin_cfg; // [RULE4] [RULE19]

  // direction register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_direction_reg <= `DIRECTION_RST; // [RULE18]
    end else if (ce_i && wr_at(req, `OFF_DIRECTION)) begin
      pin_direction_reg <= req.wdata[PORT_W-1:0];
    end
  end

  // output latch; pin-value writes land here with pin-based read data
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      output_latch_reg <= '0;
    end else if (ce_i && (wr_at(req, `OFF_LATCH) || wr_at(req, `OFF_PIN_VALUE))) begin
      output_latch_reg <= req.wdata[PORT_W-1:0]; // [RULE19] [RULE6]
    end
  end

  // open-drain and analog configuration
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      open_drain_ctl <= '0;
      analog_pin_cfg <= `ANALOG_CFG_RST; // [RULE3]
    end else if (ce_i) begin
      if (wr_at(req, `OFF_OPEN_DRAIN)) begin
        open_drain_ctl <= req.wdata[PORT_W-1:0];
      end
      if (wr_at(req, `OFF_ANALOG_CFG)) begin
        analog_pin_cfg <= req.wdata[PORT_W-1:0];
      end
    end
  end

  // change-notify enables and pull-ups
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      change_irq_enable_1 <= '0;
      change_irq_enable_2 <= '0;
      pullup_enable_1 <= '0;
      pullup_enable_2 <= '0;
    end else if (ce_i) begin
      if (wr_at(req, `OFF_CHG_EN_1)) change_irq_enable_1 <= req.wdata;
      if (wr_at(req, `OFF_CHG_EN_2)) change_irq_enable_2 <= req.wdata;
      if (wr_at(req, `OFF_PULLUP_1)) pullup_enable_1 <= req.wdata;
      if (wr_at(req, `OFF_PULLUP_2)) pullup_enable_2 <= req.wdata;
    end
  end

  // unlock key on the oscillator control low byte, then lock bit write
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      key_state <= gpio_remap_pkg::KEY_IDLE;
      map_write_lock <= 1'b0;
    end else if (ce_i && wr_at(req, `OFF_OSC_CTL)) begin
      // a wrong second key drops back to idle
      unique case (key_state)
        gpio_remap_pkg::KEY_IDLE: begin
          if (req.wdata[7:0] == `KEY_FIRST) key_state <= gpio_remap_pkg::KEY_GOT_FIRST;
        end
        gpio_remap_pkg::KEY_GOT_FIRST: begin
          key_state <= (req.wdata[7:0] == `KEY_SECOND) ? gpio_remap_pkg::KEY_OPEN
                                                         : gpio_remap_pkg::KEY_IDLE;
        end
        gpio_remap_pkg::KEY_OPEN: begin
          map_write_lock <= req.wdata[`LOCK_BIT]; // [RULE16]
          key_state <= gpio_remap_pkg::KEY_IDLE;
        end
        default: key_state <= gpio_remap_pkg::KEY_IDLE;
      endcase
    end
  end

  // map registers: two 5-bit fields per word, inputs 2k and 2k+1
  // map window covers only the words that hold fields
  assign map_hit = req.addr >= `OFF_MAP_BASE &&
                   req.addr < `OFF_MAP_BASE + `ADDR_W'((MAP_INPUTS + 1) / 2);
  assign map_idx = req.addr - `OFF_MAP_BASE;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < MAP_INPUTS; i++) map_sel[i] <= `MAP_SEL_RST; // [RULE17]
    end else if (ce_i && req.wr && map_hit && !map_write_lock) begin // [RULE16]
      for (int i = 0; i < MAP_INPUTS; i++) begin
        if (in_slot(i, map_idx)) begin
          map_sel[i] <= (i % 2 == 0) ? req.wdata[`LO_SEL_POS +: SEL_W]
                                     : req.wdata[`HI_SEL_POS +: SEL_W];
        end
      end
    end
  end

  // peripheral inputs from synchronised remap pins, output drive untouched
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      periph_in_o <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < MAP_INPUTS; i++) begin
        periph_in_o[i] <= pick_pin(map_sel[i], remap_sync); // [RULE12] [RULE14] [RULE15]
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= '0;
      if (req.rd) begin
        unique case (req.addr)
          `OFF_DIRECTION: rdata_o <= 16'(pin_direction_reg);
          `OFF_PIN_VALUE: rdata_o <= 16'(pin_value); // [RULE6]
          `OFF_LATCH: rdata_o <= 16'(output_latch_reg);
          `OFF_OPEN_DRAIN: rdata_o <= 16'(open_drain_ctl);
          `OFF_ANALOG_CFG: rdata_o <= 16'(analog_pin_cfg);
          `OFF_CHG_EN_1: rdata_o <= change_irq_enable_1;
          `OFF_CHG_EN_2: rdata_o <= change_irq_enable_2;
          `OFF_PULLUP_1: rdata_o <= pullup_enable_1;
          `OFF_PULLUP_2: rdata_o <= pullup_enable_2;
          `OFF_OSC_CTL: rdata_o[`LOCK_BIT] <= map_write_lock;
          `OFF_CHG_STATUS: rdata_o <= {15'h0, change_irq_o};
          default: begin
            if (map_hit) begin
              for (int i = 0; i < MAP_INPUTS; i++) begin
                if (in_slot(i, map_idx)) begin
                  if (i % 2 == 0) rdata_o[`LO_SEL_POS +: SEL_W] <= map_sel[i];
                  else rdata_o[`HI_SEL_POS +: SEL_W] <= map_sel[i];
                end
              end
            end
          end
        endcase
      end
    end
  end

  // pin drivers: open drain only ever drives low
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_o <= '0;
      pin_oe_o <= '0;
    end else if (ce_i) begin
      pin_o <= output_latch_reg & ~open_drain_ctl; // [RULE1]
      pin_oe_o <= ~pin_direction_reg & ~(open_drain_ctl & output_latch_reg); // [RULE1] [RULE18]
    end
  end

  // analog select high while the pin is analog
  assign analog_sel_o = ~analog_pin_cfg;
  assign pullup_en_o = pu_all[CHG_W-1:0]; // [RULE9]
  assign map_write_lock_o = map_write_lock;
endmodule

/* shared/gpio_remap_defines.svh */
// register offsets, field positions, reset values and constants for the port block
`ifndef GPIO_REMAP_DEFINES_SVH
`define GPIO_REMAP_DEFINES_SVH

`define ADDR_W 6
`define OFF_DIRECTION 6'h00
`define OFF_PIN_VALUE 6'h01
`define OFF_LATCH 6'h02
`define OFF_OPEN_DRAIN 6'h03
`define OFF_ANALOG_CFG 6'h04
`define OFF_CHG_EN_1 6'h05
`define OFF_CHG_EN_2 6'h06
`define OFF_PULLUP_1 6'h07
`define OFF_PULLUP_2 6'h08
`define OFF_OSC_CTL 6'h09
`define OFF_CHG_STATUS 6'h0a
`define OFF_MAP_BASE 6'h10

`define DIRECTION_RST 16'hffff
`define ANALOG_CFG_RST 16'h0000
`define MAP_SEL_RST 5'h1f
`define MAP_SEL_GND 5'h1f
`define KEY_FIRST 8'h46
`define KEY_SECOND 8'h57
`define LOCK_BIT 6
`define HI_SEL_POS 8
`define LO_SEL_POS 0

`endif

/* shared/gpio_remap_pkg.sv */
// types shared by the port block
package gpio_remap_pkg;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT_FIRST = 2'b01,
    KEY_OPEN = 2'b11
  } key_state_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

/* hdl/pin_sync2.sv */
// two-stage synchroniser for a vector of pin levels
module pin_sync2 #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else if (ce_i) begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

/* hdl/change_detect.sv */
// change-notification edge detector with sticky flag
module change_detect #(
  parameter int WIDTH = 31
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] level_i,
  input wire logic [WIDTH-1:0] enable_i,
  input wire logic clear_i,
  output logic flag_o
);
  logic [WIDTH-1:0] prev;
  logic hit;

  // any enabled pin whose level moved since the last sample
  assign hit = |((level_i ^ prev) & enable_i); // [RULE20]

  // previous sample of every level, frozen only by the clock enable
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prev <= '0;
    end else if (ce_i) begin
      prev <= level_i;
    end
  end

  // a change in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (ce_i) begin
      flag_o <= hit | (flag_o & ~clear_i); // [RULE7]
    end
  end
endmodule

/* testbench/port_pins_properties.sv */
// concurrent checks on the port block ports
`include "gpio_remap_defines.svh"
module port_pins_checker #(
  parameter int PORT_W = 16,
  parameter int CHG_W = 31,
  parameter int MAP_INPUTS = 14
) (
  // clock, reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [5:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  // pins
  input wire logic [PORT_W-1:0] pin_i,
  input wire logic [PORT_W-1:0] pin_oe_o,
  input wire logic [PORT_W-1:0] analog_sel_o,
  input wire logic [CHG_W-1:0] change_notify_pin_i,
  input wire logic change_irq_o,
  input wire logic [MAP_INPUTS-1:0] periph_in_o,
  input wire logic map_write_lock_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data not zero outside a read");
  pin_read_a: assert property (rd_i && addr_i == `OFF_PIN_VALUE |=>
    rdata_o == ($past(pin_i, 3) & ~analog_sel_o)) else $error("pin value read wrong");
  analog_cfg_a: assert property (wr_i && addr_i == `OFF_ANALOG_CFG |=>
    analog_sel_o == ~$past(wdata_i)) else $error("analog select does not follow write");
  reset_state_a: assert property ($fell(rst_i) |-> analog_sel_o == '1 &&
    pin_oe_o == '0 && periph_in_o == '0 && !map_write_lock_o) else $error("bad reset state");
  lock_key_a: assert property ($changed(map_write_lock_o) |-> $past(wr_i) &&
    $past(addr_i) == `OFF_OSC_CTL && $past(wdata_i[7:0], 2) == 8'h57 &&
    $past(wdata_i[7:0], 3) == 8'h46) else $error("lock changed without key");
  irq_sticky_a: assert property (change_irq_o && !(wr_i && addr_i == `OFF_CHG_STATUS)
    |=> change_irq_o) else $error("change flag dropped without clear");
  irq_quiet_a: assert property ($stable(change_notify_pin_i) [*6] ##0
    (wr_i && addr_i == `OFF_CHG_STATUS) |=> !change_irq_o) else $error("flag set with no change");
  unmapped_read_a: assert property (rd_i && addr_i == 6'h3f |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  cover property ($rose(change_irq_o));
  cover property ($rose(map_write_lock_o));
  cover property (rd_i && addr_i == `OFF_PIN_VALUE);
endmodule

bind port_pins_remap port_pins_checker #(.PORT_W(PORT_W), .CHG_W(CHG_W),
  .MAP_INPUTS(MAP_INPUTS)) i_port_pins_checker (.sys_clk_i, .rst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .pin_i, .pin_oe_o, .analog_sel_o, .change_notify_pin_i,
  .change_irq_o, .periph_in_o, .map_write_lock_o);

/* testbench/pin_partner.sv */
// board side of the port and change-notification pins
module pin_partner (
  // clock
  input wire logic sys_clk_i,
  // device drive
  input wire logic [15:0] drv_val_i,
  input wire logic [15:0] drv_en_i,
  input wire logic [30:0] pullup_i,
  // board drive
  input wire logic [15:0] port_drv_i,
  input wire logic [30:0] chg_drv_i,
  input wire logic [30:0] chg_en_i,
  // resolved levels
  output logic [15:0] port_lvl_o,
  output logic [30:0] chg_lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [30:0] float_q = 31'h0;
  // undriven pin without pull-up wanders every cycle
  always @(posedge sys_clk_i) float_q <= ~float_q;
  assign port_lvl_o = (drv_en_i & drv_val_i) | (~drv_en_i & port_drv_i);
  assign chg_lvl_o = (chg_en_i & chg_drv_i) | (~chg_en_i & (pullup_i | float_q));
endmodule

/* testbench/port_pins_remap_tb_top.sv */
// self-checking bench for the port block
`include "gpio_remap_defines.svh"
module port_pins_remap_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [5:0] addr_i = 6'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] port_drv = 16'h0000;
  logic [30:0] chg_drv = 31'h0;
  logic [30:0] chg_en = 31'h0;
  logic [25:0] remap_pin_i = 26'h0;
  logic [15:0] rdata_o, pin_i, pin_o, pin_oe_o, analog_sel_o, lat, cfg, p1, p2, w0;
  logic [30:0] cnp, pullup_en_o;
  logic [13:0] periph_in_o;
  logic change_irq_o, map_write_lock_o;
  logic [4:0] sa, sb;
  int seed = 32'h80aafcd1;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  port_pins_remap i_port_pins_remap (.sys_clk_i, .rst_i, .ce_i(ce), .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .pin_i, .pin_o, .pin_oe_o, .analog_sel_o,
    .change_notify_pin_i(cnp), .pullup_en_o, .change_irq_o, .remap_pin_i, .periph_in_o,
    .map_write_lock_o);
  pin_partner i_pin_partner (.sys_clk_i, .drv_val_i(pin_o), .drv_en_i(pin_oe_o),
    .pullup_i(pullup_en_o), .port_drv_i(port_drv), .chg_drv_i(chg_drv), .chg_en_i(chg_en),
    .port_lvl_o(pin_i), .chg_lvl_o(cnp));

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask

  task automatic nop(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  function automatic logic want(input logic [4:0] s, input logic [25:0] p);
    return (s < 5'h1a) ? p[s] : 1'b0;
  endfunction

  task automatic results();
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    chk(pin_oe_o, 16'h0000);
    rd(`OFF_DIRECTION, 16'hffff);
    rd(`OFF_ANALOG_CFG, 16'h0000);
    rd(`OFF_MAP_BASE, 16'h1f1f);
    rd(6'h3f, 16'h0000);
    wr(`OFF_LATCH, 16'hffff);
    wr(`OFF_OPEN_DRAIN, 16'h00ff);
    wr(`OFF_DIRECTION, 16'h0000);
    nop(3);
    chk({pin_oe_o, pin_o}, 32'hff00ff00);
    wr(`OFF_LATCH, 16'h0000);
    nop(3);
    chk({pin_oe_o, pin_o}, 32'hffff0000);
    wr(`OFF_DIRECTION, 16'hffff);
    for (int i = 0; i < 20; i++) begin
      lat = 16'($random(seed));
      cfg = 16'($random(seed));
      port_drv <= 16'($random(seed));
      wr(`OFF_PIN_VALUE, lat);
      wr(`OFF_ANALOG_CFG, cfg);
      nop(2);
      rd(`OFF_PIN_VALUE, port_drv & cfg);
      rd(`OFF_LATCH, lat);
    end
    p1 = 16'($random(seed));
    p2 = 16'($random(seed));
    wr(`OFF_PULLUP_1, p1);
    wr(`OFF_PULLUP_2, p2);
    nop(1);
    chk(pullup_en_o, {p2[14:0], p1});
    chg_en <= '1;
    chg_drv <= 31'($random(seed));
    wr(`OFF_CHG_EN_1, 16'hffff);
    wr(`OFF_CHG_EN_2, 16'h7fff);
    nop(6);
    wr(`OFF_CHG_STATUS, 16'h0000);
    for (int b = 0; b < 31; b++) begin
      chg_drv <= chg_drv ^ (31'h1 << b);
      nop(5);
      chk(change_irq_o, 1'b1);
      rd(`OFF_CHG_STATUS, 16'h0001);
      wr(`OFF_CHG_STATUS, 16'h0000);
      chk(change_irq_o, 1'b0);
    end
    wr(`OFF_CHG_EN_1, 16'h0000);
    wr(`OFF_CHG_EN_2, 16'h0000);
    chg_drv <= ~chg_drv;
    nop(6);
    chk(change_irq_o, 1'b0);
    for (int k = 0; k < 14; k++) begin
      sa = (k == 0) ? 5'h1f : (k == 1) ? 5'h1a : 5'($random(seed));
      sb = (k == 0) ? 5'h19 : 5'($random(seed));
      if (k % 7 == 0) w0 = {3'h0, sb, 3'h0, sa};
      remap_pin_i <= 26'($random(seed));
      wr(`OFF_MAP_BASE + 6'(k % 7), {3'h0, sb, 3'h0, sa});
      nop(4);
      chk(periph_in_o[2 * (k % 7)], want(sa, remap_pin_i));
      chk(periph_in_o[2 * (k % 7) + 1], want(sb, remap_pin_i));
    end
    wr(`OFF_OSC_CTL, 16'h0046);
    wr(`OFF_OSC_CTL, 16'h0057);
    wr(`OFF_OSC_CTL, 16'h0040);
    chk(map_write_lock_o, 1'b1);
    wr(`OFF_MAP_BASE, 16'h0000);
    rd(`OFF_MAP_BASE, w0);
    wr(`OFF_OSC_CTL, 16'h0046);
    wr(`OFF_OSC_CTL, 16'h0012);
    wr(`OFF_OSC_CTL, 16'h0000);
    chk(map_write_lock_o, 1'b1);
    wr(`OFF_OSC_CTL, 16'h0046);
    wr(`OFF_OSC_CTL, 16'h0057);
    wr(`OFF_OSC_CTL, 16'h0000);
    wr(`OFF_MAP_BASE, 16'h0000);
    rd(`OFF_MAP_BASE, 16'h0000);
    ce <= 1'b0;
    wr(`OFF_DIRECTION, 16'h1234);
    ce <= 1'b1;
    rd(`OFF_DIRECTION, 16'hffff);
    results();
  end
endmodule
